// ===== adcctl_top.sv
// control and status logic of an eight-input 10-bit SAR converter
// assumes a classic wishbone master, an on-chip timer trigger pulse
// on clk_i, and an analog mux/dac/comparator outside the block
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_map.svh"

module adcctl_top
    import adcctl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:2]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        dma_sel_i,
    input  wire logic        timer_trigger_i,
    input  wire logic        comp_i,
    output logic      [2:0]  chan_o,
    output logic             sample_o,
    output logic      [9:0]  dac_code_o,
    output logic             conv_complete_irq_o,
    output logic             irq_o
);
    function automatic logic [3:0] reg_index(input logic [31:0] ofs);
        reg_index = 4'(ofs - `ADC_BASE);
    endfunction

    // first input of a scan group
    function automatic logic [2:0] group_first(input logic [2:0] ch);
        group_first = ch[`ADC_CS_CHAN_HI] ? 3'h4 : 3'h0;
    endfunction

    localparam logic [3:0] IX_RES_A  = reg_index(`ADC_OFS_RESULT_A);
    localparam logic [3:0] IX_RES_B  = reg_index(`ADC_OFS_RESULT_B);
    localparam logic [3:0] IX_RES_C  = reg_index(`ADC_OFS_RESULT_C);
    localparam logic [3:0] IX_RES_D  = reg_index(`ADC_OFS_RESULT_D);
    localparam logic [3:0] IX_CS     = reg_index(`ADC_OFS_CTRL_STAT);
    localparam logic [3:0] IX_TC     = reg_index(`ADC_OFS_TRIG_CTRL);
    localparam logic [3:0] IX_EVST   = reg_index(`ADC_OFS_IRQ_STATUS);
    localparam logic [3:0] IX_EVMSK  = reg_index(`ADC_OFS_IRQ_MASK);
    localparam int         EVW       = `ADC_EV_WIDTH;

    // bus handshake
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;

    // registers
    logic [15:0] result_q [4];
    logic        end_flag_q;
    logic        end_seen_q;
    logic        irq_en_q;
    logic        start_q;
    logic        scan_q;
    logic        speed_q;
    logic [2:0]  chan_q;
    logic        trig_en_q;
    logic [EVW-1:0] ev_status_q;
    logic [EVW-1:0] ev_mask_q;

    // sequencer
    adcctl_state_type state_q;
    logic [2:0]  cur_q;
    logic        cs_wr;
    logic        sw_start;
    logic        sw_stop;
    logic        trig_start;
    logic        trig_miss;
    logic        go;
    logic        sar_start;
    logic        sar_done;
    logic        grp_last;
    logic        done_single;
    logic        done_group;
    logic        flag_set;
    logic        flag_clr;
    logic        scan_n;
    logic        speed_n;
    logic [2:0]  chan_n;
    adcctl_code_type code;

    // comparator synchroniser
    logic        comp_meta_q;
    logic        comp_sync_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end
        else
        begin
            comp_meta_q <= comp_i;
            comp_sync_q <= comp_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // wishbone slave: ack one cycle after the request, effects at ack
    // ---------------------------------------------------------------
    assign req   = cyc_i && stb_i;
    assign wr_en = req && we_i && ack_q;
    assign rd_en = req && !we_i && ack_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign cs_wr = wr_en && adr_i == IX_CS && sel_i[0];

    always_comb
    begin
        rdata = 32'h0000_0000;
        unique case (adr_i)
            IX_RES_A: rdata = {16'h0000, result_q[0]};
            IX_RES_B: rdata = {16'h0000, result_q[1]};
            IX_RES_C: rdata = {16'h0000, result_q[2]};
            IX_RES_D: rdata = {16'h0000, result_q[3]};
            IX_CS:    rdata = {24'h000000, end_flag_q, irq_en_q, start_q,
                               scan_q, speed_q, chan_q};
            IX_TC:    rdata = {24'h000000, trig_en_q, 7'h7F};
            IX_EVST:  rdata = {29'h0, ev_status_q};
            IX_EVMSK: rdata = {29'h0, ev_mask_q};
            default:  rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            dat_q <= (req && !ack_q && !we_i) ? rdata : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // control fields of conv_control_status and conv_trigger_control
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_en_q  <= 1'(`ADC_CS_RESET >> `ADC_CS_IRQ_EN);
            scan_q    <= 1'b0;
            speed_q   <= 1'b0;
            chan_q    <= 3'h0;
            trig_en_q <= 1'b0;
        end
        else
        begin
            if (cs_wr)
            begin
                irq_en_q <= dat_i[`ADC_CS_IRQ_EN];
                scan_q   <= dat_i[`ADC_CS_SCAN];
                speed_q  <= dat_i[`ADC_CS_SPEED];
                chan_q   <= dat_i[`ADC_CS_CHAN_HI:0];
            end
            if (wr_en && adr_i == IX_TC && sel_i[0])
                trig_en_q <= dat_i[`ADC_TC_TRIG_EN];
        end
    end

    // start requests; a trigger during a conversion is dropped
    assign sw_start   = cs_wr && dat_i[`ADC_CS_START] && !start_q;
    assign sw_stop    = cs_wr && !dat_i[`ADC_CS_START];
    assign trig_start = timer_trigger_i && trig_en_q && !start_q;
    assign trig_miss  = timer_trigger_i && trig_en_q && start_q;
    assign go         = (sw_start || trig_start) && !sw_stop;

    // fields written together with the start bit apply to that very start
    assign scan_n  = cs_wr ? dat_i[`ADC_CS_SCAN] : scan_q;
    assign speed_n = cs_wr ? dat_i[`ADC_CS_SPEED] : speed_q;
    assign chan_n  = cs_wr ? dat_i[`ADC_CS_CHAN_HI:0] : chan_q;

    // start bit: set by software or trigger, cleared by a written zero or single end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            start_q <= 1'b0;
        else if (sw_stop)
            start_q <= 1'b0;
        else if (go)
            start_q <= 1'b1;
        else if (done_single)
            start_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    assign grp_last    = cur_q == chan_q;
    assign done_single = sar_done && state_q == ADCCTL_CONV && !scan_q;
    assign done_group  = sar_done && state_q == ADCCTL_CONV && scan_q
                         && grp_last;
    assign sar_start   = (state_q == ADCCTL_IDLE && go)
                         || (sar_done && state_q == ADCCTL_CONV && scan_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ADCCTL_IDLE;
            cur_q   <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                ADCCTL_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= ADCCTL_CONV;
                        cur_q   <= scan_n ? group_first(chan_n) : chan_n;
                    end
                end
                ADCCTL_CONV:
                begin
                    if (sw_stop)
                        state_q <= ADCCTL_IDLE;
                    else if (done_single)
                        state_q <= ADCCTL_IDLE;
                    else if (sar_done)
                        cur_q <= grp_last ? group_first(chan_q)
                                          : cur_q + 3'h1;
                end
            endcase
        end
    end

    // abort drops the conversion in flight before its result lands
    adcctl_sar adcctl_sar_inst (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (sar_start),
        .abort_i  (sw_stop),
        .fast_i   (speed_n),
        .comp_i   (comp_sync_q),
        .sample_o (sample_o),
        .code_o   (code),
        .done_o   (sar_done)
    );

    assign chan_o     = cur_q;
    assign dac_code_o = code;

    // result registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
                result_q[i] <= 16'h0000;
        end
        else if (sar_done && state_q == ADCCTL_CONV && !sw_stop)
            result_q[cur_q[1:0]] <= {code, 6'h00};
    end

    // ---------------------------------------------------------------
    // end flag: set wins over any clear in the same cycle
    // ---------------------------------------------------------------
    assign flag_set = done_single || done_group;
    assign flag_clr = (cs_wr && !dat_i[`ADC_CS_END_FLAG] && end_seen_q)
                      || (req && ack_q && dma_sel_i && conv_complete_irq_o);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            end_flag_q <= 1'b0;
        else if (flag_set)
            end_flag_q <= 1'b1;
        else if (flag_clr)
            end_flag_q <= 1'b0;
    end

    // a one must be read before a written zero clears the flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            end_seen_q <= 1'b0;
        else if (flag_clr || !end_flag_q)
            end_seen_q <= 1'b0;
        else if (rd_en && adr_i == IX_CS && sel_i[0] && dat_q[`ADC_CS_END_FLAG])
            end_seen_q <= 1'b1;
    end

    assign conv_complete_irq_o = end_flag_q && irq_en_q;

    // ---------------------------------------------------------------
    // event status (write one to clear) and mask
    // ---------------------------------------------------------------
    logic [EVW-1:0] ev_set;

    always_comb
    begin
        ev_set = '0;
        ev_set[`ADC_EV_GROUP_DONE] = flag_set;
        ev_set[`ADC_EV_CONV_DONE]  = sar_done && state_q == ADCCTL_CONV && !sw_stop;
        ev_set[`ADC_EV_TRIG_MISS]  = trig_miss;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_status_q <= '0;
        else if (wr_en && adr_i == IX_EVST && sel_i[0])
            ev_status_q <= (ev_status_q & ~dat_i[EVW-1:0]) | ev_set;
        else
            ev_status_q <= ev_status_q | ev_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_mask_q <= '0;
        else if (wr_en && adr_i == IX_EVMSK && sel_i[0])
            ev_mask_q <= dat_i[EVW-1:0];
    end

    assign irq_o = |(ev_status_q & ev_mask_q);

endmodule // adcctl_top

`default_nettype wire

// ===== adcctl_map.svh
// register offsets, field positions, reset values and timing counts
// of the converter control block; definitions only
`ifndef ADCCTL_MAP_SVH
`define ADCCTL_MAP_SVH

// printed offsets; index = offset - base, byte address = 4 * index
`define ADC_BASE            32'hFFFF8420
`define ADC_OFS_RESULT_A    32'hFFFF8420
`define ADC_OFS_RESULT_B    32'hFFFF8422
`define ADC_OFS_RESULT_C    32'hFFFF8424
`define ADC_OFS_RESULT_D    32'hFFFF8426
`define ADC_OFS_CTRL_STAT   32'hFFFF8428
`define ADC_OFS_TRIG_CTRL   32'hFFFF8429
`define ADC_OFS_IRQ_STATUS  32'hFFFF842A
`define ADC_OFS_IRQ_MASK    32'hFFFF842B

// conv_control_status fields
`define ADC_CS_END_FLAG     7
`define ADC_CS_IRQ_EN       6
`define ADC_CS_START        5
`define ADC_CS_SCAN         4
`define ADC_CS_SPEED        3
`define ADC_CS_CHAN_HI      2
`define ADC_CS_RESET        8'h00

// conv_trigger_control fields
`define ADC_TC_TRIG_EN      7
`define ADC_TC_RESET        8'h7F

// event status / mask fields
`define ADC_EV_GROUP_DONE   0
`define ADC_EV_CONV_DONE    1
`define ADC_EV_TRIG_MISS    2
`define ADC_EV_WIDTH        3

// result layout
`define ADC_RES_LSB         6

// conversion time in states (one state = one clock)
`define ADC_STATES_SLOW     266
`define ADC_STATES_FAST     134
`define ADC_STEP_SLOW       20
`define ADC_STEP_FAST       10

`endif

// ===== adcctl_pkg.sv
// types shared by the converter control block
// assumes adcctl_map.svh for the numeric layout
package adcctl_pkg;

    typedef enum logic [1:0] {
        ADCCTL_IDLE = 2'b01,
        ADCCTL_CONV = 2'b10
    } adcctl_state_type;

    typedef logic [9:0] adcctl_code_type;

endpackage

// ===== adcctl_sar.sv
// successive-approximation sequencer: one sample phase, ten bit trials
// assumes comp_i is already synchronised; trial code drives the dac
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_map.svh"

module adcctl_sar
    import adcctl_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            start_i,
    input  wire logic            abort_i,
    input  wire logic            fast_i,
    input  wire logic            comp_i,
    output logic                 sample_o,
    output adcctl_code_type      code_o,
    output logic                 done_o
);
    localparam int SMP_SLOW = `ADC_STATES_SLOW - 10 * `ADC_STEP_SLOW;
    localparam int SMP_FAST = `ADC_STATES_FAST - 10 * `ADC_STEP_FAST;

    logic            busy_q;
    logic [3:0]      bit_q;
    logic [8:0]      cnt_q;
    logic            fast_q;
    adcctl_code_type code_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || abort_i)
        begin
            busy_q <= 1'b0;
            bit_q  <= 4'hA;
            cnt_q  <= 9'h000;
            fast_q <= 1'b0;
            code_q <= 10'h000;
            done_o <= 1'b0;
        end
        else if (start_i)
        begin
            busy_q <= 1'b1;
            bit_q  <= 4'hA;
            fast_q <= fast_i;
            cnt_q  <= fast_i ? 9'(SMP_FAST - 1) : 9'(SMP_SLOW - 1);
            code_q <= 10'h000;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (busy_q && cnt_q != 9'h000)
                cnt_q <= cnt_q - 9'h001;
            else if (busy_q)
            begin
                cnt_q <= fast_q ? 9'(`ADC_STEP_FAST - 1) : 9'(`ADC_STEP_SLOW - 1);
                if (bit_q == 4'hA)
                begin
                    bit_q      <= 4'h9;
                    code_q[9]  <= 1'b1;
                end
                else
                begin
                    // comparator low means trial code is above the input
                    code_q[bit_q] <= comp_i;
                    if (bit_q == 4'h0)
                    begin
                        busy_q <= 1'b0;
                        done_o <= 1'b1;
                    end
                    else
                    begin
                        code_q[bit_q - 4'h1] <= 1'b1;
                        bit_q                <= bit_q - 4'h1;
                    end
                end
            end
        end
    end

    assign sample_o = busy_q && bit_q == 4'hA;
    assign code_o   = code_q;

endmodule // adcctl_sar

`default_nettype wire

// ===== adcctl_top_asserts.sv
// checker for the converter control block, bound to adcctl_top
// assumes a single clock domain and sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module adcctl_checker
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:2]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        dma_sel_i,
    input wire logic [2:0]  chan_o,
    input wire logic        sample_o,
    input wire logic        conv_complete_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [7:0] cs_q;
    logic [7:0] samp_q;
    logic       cs_wr;

    // shadow of the last control write; self-clear of start is not seen
    assign cs_wr = ack_o && we_i && adr_i == 4'h8 && sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cs_q <= 8'h00;
        else if (cs_wr)
            cs_q <= dat_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        samp_q <= sample_o ? samp_q + 8'h01 : 8'h00;
    end

    property p_ack_next;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");

    property p_res_low;
        ack_o && !we_i && !adr_i[5] |-> dat_o[5:0] == 6'h00 && dat_o[31:16] == 16'h0000;
    endproperty
    a_res_low: assert property (p_res_low) else $error("result not left-justified");

    property p_irq_fall;
        $fell(conv_complete_irq_o) |-> $past(ack_o && (dma_sel_i || (we_i && adr_i == 4'h8)));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("end interrupt dropped without access");

    property p_reset_idle;
        $fell(rst_i) |-> !sample_o && !conv_complete_irq_o && !ack_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    property p_single_chan;
        sample_o && cs_q[5] && !cs_q[4] |-> chan_o == cs_q[2:0];
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("wrong single channel");

    property p_scan_grp;
        sample_o && cs_q[5] && cs_q[4] |-> chan_o[2] == cs_q[2] && chan_o[1:0] <= cs_q[1:0];
    endproperty
    a_scan_grp: assert property (p_scan_grp) else $error("channel outside scan group");

    property p_samp_len;
        $fell(sample_o) && cs_q[5] |-> samp_q == (cs_q[3] ? 8'h22 : 8'h42);
    endproperty
    a_samp_len: assert property (p_samp_len) else $error("sample phase length wrong");

    property p_abort;
        cs_wr && !dat_i[5] |-> ##2 !sample_o [*4];
    endproperty
    a_abort: assert property (p_abort) else $error("conversion kept running after stop");

    property p_scan_more;
        $fell(sample_o) && cs_q[5] && cs_q[4] |-> ##[1:210] (sample_o || !cs_q[5]);
    endproperty
    a_scan_more: assert property (p_scan_more) else $error("scan did not continue");

    c_done: cover property ($rose(conv_complete_irq_o));
    c_dma: cover property (ack_o && dma_sel_i && conv_complete_irq_o);
    c_scan: cover property ($fell(sample_o) && cs_q[4] && cs_q[5]);
endmodule // adcctl_checker

bind adcctl_top adcctl_checker adcctl_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .dma_sel_i(dma_sel_i), .chan_o(chan_o), .sample_o(sample_o),
    .conv_complete_irq_o(conv_complete_irq_o));
`default_nettype wire

// ===== adcctl_far_model.sv
// analog side model: eight inputs at fixed levels, comparator, timer trigger
// assumes the converter block shares clk_i and resynchronises comp_o
`timescale 1ns/1ps
`default_nettype none
module adcctl_far_model
#(
    parameter logic [79:0] LEVELS = 80'h0
)
(
    input  wire logic       clk_i,
    input  wire logic [2:0] chan_i,
    input  wire logic [9:0] dac_i,
    input  wire logic       fire_i,
    output logic            comp_o,
    output logic            trigger_o
);
    logic fire_q;

    // ideal comparator, input at or above the trial code
    assign comp_o = LEVELS[chan_i * 10 +: 10] >= dac_i;

    always_ff @(posedge clk_i)
    begin
        fire_q    <= fire_i;
        trigger_o <= fire_i && !fire_q; // one pulse per request, never a level
    end
endmodule // adcctl_far_model
`default_nettype wire

// ===== adcctl_bench.sv
// self-checking bench for the converter control block
// assumes adcctl_top, its bound checker and the analog/timer model
`timescale 1ns/1ps
`default_nettype none
module adcctl_bench;
    localparam logic [79:0] LEVELS = {10'h30F, 10'h0F0, 10'h1FF, 10'h200, 10'h155, 10'h2AA, 10'h3FF, 10'h001};

    logic        clk_i, rst_i, cyc_i, stb_i, we_i, dma_sel_i, fire;
    logic        timer_trigger_i, comp_i, ack_o, sample_o, conv_complete_irq_o, irq_o;
    logic [5:2]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [2:0]  chan_o;
    logic [9:0]  dac_code_o;
    int          errors, checks_done, n_wait;

    adcctl_top adcctl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dma_sel_i(dma_sel_i),
        .timer_trigger_i(timer_trigger_i), .comp_i(comp_i), .chan_o(chan_o), .sample_o(sample_o),
        .dac_code_o(dac_code_o), .conv_complete_irq_o(conv_complete_irq_o), .irq_o(irq_o));

    adcctl_far_model #(.LEVELS(LEVELS)) adcctl_far_model_inst (.clk_i(clk_i), .chan_i(chan_o),
        .dac_i(dac_code_o), .fire_i(fire), .comp_o(comp_i), .trigger_o(timer_trigger_i));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [31:0] res(int c);
        return {16'h0000, LEVELS[c * 10 +: 10], 6'h00};
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic dma);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        dma_sel_i <= dma;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        chk({31'h0, ack_o}, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        dma_sel_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp);
    endtask

    task automatic wait_irq();
        n_wait = 0;
        do
        begin
            @(posedge clk_i);
            n_wait++;
        end
        while (conv_complete_irq_o !== 1'b1 && n_wait < 400);
    endtask

    task automatic pulse();
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    initial
    begin
        // watchdog, well beyond the roughly 10700 cycles the tests need
        repeat (30000) @(posedge clk_i);
        errors++;
        summarize();
    end

    initial
    begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, dma_sel_i, fire} = 5'h00;
        adr_i = 4'h0;
        sel_i = 4'hF;
        dat_i = 32'h0;
        errors = 0;
        checks_done = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i += 2) rc(4'(i), 32'h0);
        rc(4'h8, 32'h00);
        rc(4'h9, 32'h7F);
        rc(4'h1, 32'h0);
        wr(4'h0, 32'hFFFF);
        rc(4'h0, 32'h0);
        wr(4'h8, 32'h65);
        wait_irq();
        chk({31'h0, n_wait >= 255 && n_wait <= 270}, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        rc(4'h8, 32'hC5);
        rc(4'h2, res(5));
        wr(4'h8, 32'hC5);
        rc(4'h8, 32'hC5);
        wr(4'h8, 32'h45);
        rc(4'h8, 32'h45);
        chk({31'h0, conv_complete_irq_o}, 32'h0);
        rc(4'hA, 32'h3);
        wr(4'hB, 32'h3);
        tick(2);
        chk({31'h0, irq_o}, 32'h1);
        wr(4'hA, 32'h3);
        tick(2);
        chk({31'h0, irq_o}, 32'h0);
        wr(4'h8, 32'h3E);
        tick(2 * 136);
        rc(4'h8, 32'h3E);
        tick(146);
        rc(4'h8, 32'hBE);
        chk({31'h0, conv_complete_irq_o}, 32'h0);
        wr(4'h8, 32'h1E);
        tick(300);
        rc(4'h8, 32'h1E);
        chk({31'h0, sample_o}, 32'h0);
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 8; c++)
            begin
                wr(4'h8, 32'h28 | (m << 4) | c);
                tick(4 * 136 + 10);
                wr(4'h8, 32'h08);
                rc(4'(2 * (c % 4)), res(c));
            end
        rc(4'h8, 32'h88);
        wr(4'h8, 32'h03);
        rc(4'h8, 32'h03);
        pulse();
        tick(10);
        chk({31'h0, sample_o}, 32'h0);
        wr(4'h9, 32'h80);
        rc(4'h9, 32'hFF);
        pulse();
        tick(280);
        rc(4'h8, 32'h83);
        rc(4'h6, res(3));
        wr(4'h8, 32'h61);
        pulse();
        wait_irq();
        chk({31'h0, conv_complete_irq_o}, 32'h1);
        bus(1'b0, 4'h2, 32'h0, 1'b1);
        chk(rd, res(1));
        tick(1);
        chk({31'h0, conv_complete_irq_o}, 32'h0);
        rc(4'h8, 32'h41);
        rc(4'hA, 32'h7);
        summarize();
    end
endmodule // adcctl_bench
`default_nettype wire
